// *** src/charger_status_pkg.sv ***
// Package with register map, field positions and carriers for the charger status flags
// ----------------------------------------------------------------------------
// Operation
// - State bit 4 reads 1 while regulating on input voltage forward or output voltage in reverse mode.
// - State bit 3 is a read-only input current regulation indicator in forward mode, reset to 0.
// - State bit 2 reads 1 while in fast charge.
// - State bit 1 reads 1 while in pre-charge.
// - State bit 0 reads 1 while supplying power from the battery out to the port in reverse mode.
// - Fault bit 7 latches input overvoltage until a host read clears it.
// - Fault bit 5 latches input overcurrent until a host read, as do fault bits 2, 1 and 0.
// - In normal operation fault bit 6 is set only by battery overcurrent and cleared by a read.
// - In pass-through mode bit 6 flags battery overvoltage or overcurrent when protection is on, else nothing.
// - Fault bit 4 latches system overvoltage, ignores reads, and clears only on a host write of 0 or adapter removal.
// - The power converter stays disabled while system overvoltage is present.
// - After system overvoltage ends the converter restarts only on a write of 0 to bit 4 or adapter removal.
// - Fault bit 3 latches after 7 failed restarts under system undervoltage until a host write of 0.
// - Fault bit 2 latches while the force power stage off control is 1 and clears on a host read.
// - Fault bit 1 latches reverse-mode output overvoltage and clears on a host read.
// - Fault bit 0 latches reverse-mode output undervoltage and clears on a host read.
// ----------------------------------------------------------------------------
package charger_status_pkg;

    localparam logic [7:0] FAULT_FLAGS_ADDR = 8'h20;
    localparam logic [7:0] STATE_FLAGS_ADDR = 8'h21;
    localparam logic [7:0] FAULT_RESET      = 8'h00;
    localparam logic [7:0] STATE_RESET      = 8'h00;

    // Fault byte field positions
    localparam int FLT_IN_OV   = 7;
    localparam int FLT_BAT_OC  = 6;
    localparam int FLT_IN_OC   = 5;
    localparam int FLT_SYS_OV  = 4;
    localparam int FLT_SYS_UV  = 3;
    localparam int FLT_FORCE   = 2;
    localparam int FLT_REV_OV  = 1;
    localparam int FLT_REV_UV  = 0;

    // Bits cleared by a host read
    localparam logic [7:0] READ_CLEAR_MASK  = 8'hE7;
    // Bits cleared by a host write of 0
    localparam logic [7:0] WRITE_CLEAR_MASK = 8'h18;

    localparam int          UV_RETRY_LIMIT  = 7;
    localparam int          UV_CNT_W        = 3;

    // Analog-side condition levels
    typedef struct packed {
        logic input_voltage_regulation;
        logic reverse_voltage_regulation;
        logic input_current_regulation;
        logic fast_charge;
        logic precharge;
        logic reverse_power_mode;
    } state_cond_s;

    typedef struct packed {
        logic input_overvoltage;
        logic battery_overcurrent;
        logic battery_overvoltage;
        logic input_overcurrent;
        logic system_overvoltage;
        logic system_undervoltage;
        logic restart_fail;
        logic reverse_overvoltage;
        logic reverse_undervoltage;
        logic adapter_present;
    } fault_cond_s;

    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_s;

endpackage

// *** src/charger_status_fault_flags.sv ***
// Charger state and fault flag register pair with latch-until-read and write-zero clear
`timescale 1ns/10ps
module charger_status_fault_flags #(
    parameter int UV_RETRIES = charger_status_pkg::UV_RETRY_LIMIT
) (
    input  wire logic                            core_clk_i,
    input  wire logic                            rstn_i,
    input  wire logic                            clk_en_i,
    input  wire charger_status_pkg::state_cond_s state_cond_i,
    input  wire charger_status_pkg::fault_cond_s fault_cond_i,
    input  wire logic                            pass_through_mode_i,
    input  wire logic                            battery_overcurrent_protect_enable_i,
    input  wire logic                            force_power_stage_off_i,
    input  wire charger_status_pkg::reg_req_s    req_i,
    output logic [7:0]                           rdata_o,
    output logic                                 rvalid_o,
    output logic                                 converter_enable_o
);

    // Counter is UV_CNT_W bits wide, so the retry count must fit below its wrap
    if (UV_RETRIES < 1 || UV_RETRIES > 2 ** charger_status_pkg::UV_CNT_W - 1) begin : g_bad_retries
        $error("UV_RETRIES out of range");
    end

    // ------------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------------
    // Analog conditions are asynchronous to the core clock
    charger_status_pkg::state_cond_s st_meta_reg, st_sync_reg;
    charger_status_pkg::fault_cond_s fc_meta_reg, fc_sync_reg;
    logic [2:0]                      ctl_meta_reg, ctl_sync_reg;

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_meta_reg  <= '0;
            st_sync_reg  <= '0;
            fc_meta_reg  <= '0;
            fc_sync_reg  <= '0;
            ctl_meta_reg <= '0;
            ctl_sync_reg <= '0;
        end else if (clk_en_i) begin
            st_meta_reg  <= state_cond_i;
            st_sync_reg  <= st_meta_reg;
            fc_meta_reg  <= fault_cond_i;
            fc_sync_reg  <= fc_meta_reg;
            ctl_meta_reg <= {pass_through_mode_i, battery_overcurrent_protect_enable_i, force_power_stage_off_i};
            ctl_sync_reg <= ctl_meta_reg;
        end
    end

    // Control levels share one synchroniser pair
    logic pass_thru;
    logic bat_prot_en;
    logic force_off;
    assign pass_thru   = ctl_sync_reg[2];
    assign bat_prot_en = ctl_sync_reg[1];
    assign force_off   = ctl_sync_reg[0];

    // ------------------------------------------------------------------------
    // State byte
    // ------------------------------------------------------------------------
    logic [7:0] state_reg;

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_reg <= charger_status_pkg::STATE_RESET;
        end else if (clk_en_i) begin
            state_reg[7:5] <= 3'h0;
            state_reg[4]   <= (st_sync_reg.input_voltage_regulation & ~st_sync_reg.reverse_power_mode)
                            | (st_sync_reg.reverse_voltage_regulation & st_sync_reg.reverse_power_mode);
            state_reg[3]   <= st_sync_reg.input_current_regulation & ~st_sync_reg.reverse_power_mode;
            state_reg[2]   <= st_sync_reg.fast_charge;
            state_reg[1]   <= st_sync_reg.precharge;
            state_reg[0]   <= st_sync_reg.reverse_power_mode;
        end
    end

    // ------------------------------------------------------------------------
    // Undervoltage restart counter
    // ------------------------------------------------------------------------
    logic [charger_status_pkg::UV_CNT_W-1:0] uv_cnt_reg;
    logic                                    uv_trip;

    assign uv_trip = fc_sync_reg.system_undervoltage && fc_sync_reg.restart_fail
                     && (uv_cnt_reg == charger_status_pkg::UV_CNT_W'(UV_RETRIES - 1));

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            uv_cnt_reg <= '0;
        end else if (clk_en_i) begin
            if (!fc_sync_reg.system_undervoltage) begin
                uv_cnt_reg <= '0;
            end else if (fc_sync_reg.restart_fail && !uv_trip) begin
                uv_cnt_reg <= uv_cnt_reg + 1'b1;
            end
        end
    end

    // Failed restart is a level per attempt; edge detect on the synced copy
    logic rf_prev_reg;
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rf_prev_reg <= 1'b0;
        end else if (clk_en_i) begin
            rf_prev_reg <= fc_sync_reg.restart_fail;
        end
    end

    // ------------------------------------------------------------------------
    // Register select
    // ------------------------------------------------------------------------
    // One compare serves the read, write and answer paths
    function automatic logic addr_is(input logic [7:0] addr, input logic [7:0] target);
        return addr == target;
    endfunction

    logic       rd_fault;
    logic       wr_fault;
    logic       rd_state;

    assign rd_fault = req_i.rd && addr_is(req_i.addr, charger_status_pkg::FAULT_FLAGS_ADDR);
    assign wr_fault = req_i.wr && addr_is(req_i.addr, charger_status_pkg::FAULT_FLAGS_ADDR);
    assign rd_state = req_i.rd && addr_is(req_i.addr, charger_status_pkg::STATE_FLAGS_ADDR);

    // ------------------------------------------------------------------------
    // Fault byte
    // ------------------------------------------------------------------------
    logic [7:0] fault_reg;
    logic [7:0] fault_set;
    logic [7:0] fault_next;

    always_comb begin
        fault_set = '0;
        fault_set[charger_status_pkg::FLT_IN_OV]  = fc_sync_reg.input_overvoltage;
        fault_set[charger_status_pkg::FLT_BAT_OC] = pass_thru ? (bat_prot_en && (fc_sync_reg.battery_overcurrent
                                                                              || fc_sync_reg.battery_overvoltage))
                                                              : fc_sync_reg.battery_overcurrent;
        fault_set[charger_status_pkg::FLT_IN_OC]  = fc_sync_reg.input_overcurrent;
        fault_set[charger_status_pkg::FLT_SYS_OV] = fc_sync_reg.system_overvoltage;
        fault_set[charger_status_pkg::FLT_SYS_UV] = uv_trip && !rf_prev_reg;
        fault_set[charger_status_pkg::FLT_FORCE]  = force_off;
        fault_set[charger_status_pkg::FLT_REV_OV] = fc_sync_reg.reverse_overvoltage;
        fault_set[charger_status_pkg::FLT_REV_UV] = fc_sync_reg.reverse_undervoltage;
    end

    always_comb begin
        fault_next = fault_reg;
        if (rd_fault) begin
            fault_next = fault_next & ~charger_status_pkg::READ_CLEAR_MASK;
        end
        if (wr_fault) begin
            // Only bits 4 and 3 are writable, and only toward 0
            fault_next = fault_next & ~(charger_status_pkg::WRITE_CLEAR_MASK & ~req_i.wdata);
        end
        if (!fc_sync_reg.adapter_present) begin
            fault_next[charger_status_pkg::FLT_SYS_OV] = 1'b0;
        end
        fault_next = fault_next | fault_set;
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            fault_reg <= charger_status_pkg::FAULT_RESET;
        end else if (clk_en_i) begin
            fault_reg <= fault_next;
        end
    end

    // ------------------------------------------------------------------------
    // Converter enable and read port
    // ------------------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            converter_enable_o <= 1'b0;
        end else if (clk_en_i) begin
            converter_enable_o <= !fc_sync_reg.system_overvoltage
                                  && !fault_next[charger_status_pkg::FLT_SYS_OV];
        end
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rvalid_o <= 1'b0;
        end else if (clk_en_i) begin
            rvalid_o <= req_i.rd;
        end
    end

    // Unmapped reads answer zero so the host never sees stale data
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_o <= 8'h00;
        end else if (clk_en_i) begin
            if (rd_fault) begin
                rdata_o <= fault_reg;
            end else if (rd_state) begin
                rdata_o <= state_reg;
            end else if (req_i.rd) begin
                rdata_o <= 8'h00;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);

    a_inov_latch: assert property (clk_en_i && fc_sync_reg.input_overvoltage |=> fault_reg[7])
        else $error("input overvoltage not latched");
    a_inoc_hold: assert property (clk_en_i && fault_reg[5] && !rd_fault |=> fault_reg[5])
        else $error("input overcurrent dropped without read");
    a_read_clear: assert property (clk_en_i && rd_fault && fault_set == 8'h00
                                   |=> (fault_reg & charger_status_pkg::READ_CLEAR_MASK) == 8'h00)
        else $error("read did not clear latched faults");
    a_sysov_read: assert property (clk_en_i && fault_reg[4] && !wr_fault && fc_sync_reg.adapter_present
                                   |=> fault_reg[4])
        else $error("system overvoltage cleared without write");
    a_conv_off: assert property (clk_en_i && fc_sync_reg.system_overvoltage |=> !converter_enable_o)
        else $error("converter enabled during system overvoltage");
    a_conv_held: assert property (clk_en_i && fault_reg[4] && !wr_fault && fc_sync_reg.adapter_present
                                  |=> !converter_enable_o)
        else $error("converter restarted before clear");
    a_batfault_passthru: assert property (clk_en_i && pass_thru && !bat_prot_en
                                          && !fault_reg[6] |=> !fault_reg[6])
        else $error("battery fault flagged with protection off");
    a_force_latch: assert property (clk_en_i && force_off |=> fault_reg[2])
        else $error("force off fault not latched");
    // Set wins over the read clear
    a_same_cycle: assert property (clk_en_i && rd_fault && fc_sync_reg.reverse_overvoltage |=> fault_reg[1])
        else $error("fault lost on read");
    a_state_rev: assert property (clk_en_i |=> state_reg[0] == $past(st_sync_reg.reverse_power_mode))
        else $error("reverse power state wrong");

    // ------------------------------------------------------------------------
    // State byte checks
    // ------------------------------------------------------------------------
    a_state_volt: assert property (clk_en_i && st_sync_reg.input_voltage_regulation
                                   && !st_sync_reg.reverse_power_mode |=> state_reg[4])
        else $error("input voltage regulation not shown");
    // In reverse mode bit 4 follows output voltage regulation
    a_state_volt_rev: assert property (clk_en_i && st_sync_reg.reverse_power_mode
                                       |=> state_reg[4] == $past(st_sync_reg.reverse_voltage_regulation))
        else $error("reverse voltage regulation not shown");
    a_state_curr: assert property (clk_en_i && st_sync_reg.reverse_power_mode |=> !state_reg[3])
        else $error("current regulation shown in reverse mode");
    a_state_fast: assert property (clk_en_i |=> state_reg[2] == $past(st_sync_reg.fast_charge))
        else $error("fast charge state wrong");
    a_state_pre: assert property (clk_en_i |=> state_reg[1] == $past(st_sync_reg.precharge))
        else $error("pre-charge state wrong");

    // ------------------------------------------------------------------------
    // Fault byte checks
    // ------------------------------------------------------------------------
    a_inov_hold: assert property (clk_en_i && fault_reg[7] && !rd_fault |=> fault_reg[7])
        else $error("input overvoltage dropped without read");
    a_batfault_set: assert property (clk_en_i && !pass_thru && fc_sync_reg.battery_overcurrent
                                     |=> fault_reg[6])
        else $error("battery overcurrent not latched");
    a_batfault_quiet: assert property (clk_en_i && !pass_thru && !fc_sync_reg.battery_overcurrent
                                       && !fault_reg[6] |=> !fault_reg[6])
        else $error("battery fault set without overcurrent");
    a_sysuv_hold: assert property (clk_en_i && fault_reg[3] && !wr_fault |=> fault_reg[3])
        else $error("system undervoltage cleared without write");
    a_sysuv_quiet: assert property (clk_en_i && !fc_sync_reg.system_undervoltage && !fault_reg[3]
                                    |=> !fault_reg[3])
        else $error("system undervoltage set without undervoltage");
    a_revov_latch: assert property (clk_en_i && fc_sync_reg.reverse_overvoltage |=> fault_reg[1])
        else $error("reverse overvoltage not latched");
    a_revuv_latch: assert property (clk_en_i && fc_sync_reg.reverse_undervoltage |=> fault_reg[0])
        else $error("reverse undervoltage not latched");
    a_ones_ignored: assert property (clk_en_i && wr_fault && req_i.wdata[4] && fault_reg[4]
                                     && fc_sync_reg.adapter_present |=> fault_reg[4])
        else $error("write of one cleared system overvoltage");
    // A frozen core holds every flag, whatever its inputs do
    a_freeze_hold: assert property (!clk_en_i |=> $stable(fault_reg) && $stable(state_reg))
        else $error("flags moved while clock enable low");

    // ------------------------------------------------------------------------
    // Read port and converter checks
    // ------------------------------------------------------------------------
    a_read_valid: assert property (clk_en_i && req_i.rd |=> rvalid_o)
        else $error("read not answered");
    a_read_data: assert property (clk_en_i && rd_fault |=> rdata_o == $past(fault_reg))
        else $error("fault byte read data wrong");
    a_read_state: assert property (clk_en_i && rd_state |=> rdata_o == $past(state_reg))
        else $error("state byte read data wrong");
    a_read_unmapped: assert property (clk_en_i && req_i.rd && !rd_fault && !rd_state |=> rdata_o == 8'h00)
        else $error("unmapped read not zero");
    // Unplugging the adapter is the host-free way back on
    a_conv_back: assert property (clk_en_i && !fc_sync_reg.adapter_present
                                  && !fc_sync_reg.system_overvoltage |=> converter_enable_o)
        else $error("converter not re-enabled after adapter removal");

    // ------------------------------------------------------------------------
    // Coverage
    // ------------------------------------------------------------------------
    c_read_fault: cover property (rd_fault && fault_reg != 8'h00);
    c_sysov_clear: cover property (fault_reg[4] && wr_fault && !req_i.wdata[4]);
    c_uv_trip: cover property (uv_trip);
    c_state_rev: cover property (state_reg[0] && state_reg[4]);
    c_frozen: cover property (!clk_en_i ##1 clk_en_i);

endmodule // charger_status_fault_flags

// *** sim/host_model.sv ***
// Host model that issues register reads and writes on the request carrier
`timescale 1ns/10ps
module host_model (
    input  wire logic                    core_clk_i,
    input  wire logic [7:0]              rdata_i,
    input  wire logic                    rvalid_i,
    output charger_status_pkg::reg_req_s req_o
);
    initial req_o = '0;

    // Strobe held across the taking edge; address inverted once released
    task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] wd,
                          output logic [7:0] d, output logic v);
        @(posedge core_clk_i);
        #1;
        req_o = '{rd: ~wr, wr: wr, addr: a, wdata: wd};
        @(posedge core_clk_i);
        #1;
        req_o = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~wd};
        v = rvalid_i;
        d = rdata_i;
    endtask
endmodule // host_model

// *** sim/tb_top.sv ***
// Self-checking bench for the charger state and fault flag registers
`timescale 1ns/10ps
module tb_top;
    localparam int NUV = charger_status_pkg::UV_RETRY_LIMIT;
    logic                            core_clk_i = 1'b0;
    logic                            rstn_i = 1'b0;
    charger_status_pkg::state_cond_s state_cond = '0;
    logic [9:0]                      fault_v = 10'h001;
    logic                            pass_thru = 1'b0;
    logic                            clk_en = 1'b1;
    logic                            prot_en = 1'b0;
    logic                            force_off = 1'b0;
    charger_status_pkg::reg_req_s    req;
    logic [7:0]                      rdata;
    logic                            rvalid;
    logic                            conv_en;
    int                              miscompares = 0;
    int                              cmp_count = 0;
    int                              cycles = 0;
    int                              seed = 32'hEAC15CE3;
    logic [7:0]                      d;
    logic                            v;

    always #12.5 core_clk_i = ~core_clk_i;

    charger_status_fault_flags #(.UV_RETRIES(NUV)) i_dut (
        .core_clk_i                          (core_clk_i),
        .rstn_i                              (rstn_i),
        .clk_en_i                            (clk_en),
        .state_cond_i                        (state_cond),
        .fault_cond_i                        (fault_v),
        .pass_through_mode_i                 (pass_thru),
        .battery_overcurrent_protect_enable_i(prot_en),
        .force_power_stage_off_i             (force_off),
        .req_i                               (req),
        .rdata_o                             (rdata),
        .rvalid_o                            (rvalid),
        .converter_enable_o                  (conv_en)
    );

    host_model i_host (
        .core_clk_i(core_clk_i),
        .rdata_i   (rdata),
        .rvalid_i  (rvalid),
        .req_o     (req)
    );

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] exp_state(charger_status_pkg::state_cond_s s);
        return {3'h0, s.reverse_power_mode ? s.reverse_voltage_regulation : s.input_voltage_regulation,
                s.input_current_regulation & ~s.reverse_power_mode, s.fast_charge, s.precharge,
                s.reverse_power_mode};
    endfunction

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        i_host.access(1'b0, a, 8'h00, d, v);
        chk("rvalid", 8'h01, {7'h00, v});
        chk("rdata", exp, d);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] wd);
        i_host.access(1'b1, a, wd, d, v);
        tick(3);
    endtask

    // Pulse a fault level, then read twice: latched value, then cleared
    task automatic pulse_chk(input logic [9:0] f, input logic [7:0] exp);
        fault_v = f | 10'h001;
        tick(5);
        fault_v = 10'h001;
        tick(4);
        rd_chk(charger_status_pkg::FAULT_FLAGS_ADDR, exp);
        rd_chk(charger_status_pkg::FAULT_FLAGS_ADDR, 8'h00);
    endtask

    task automatic conclude;
        $display("Comparisons %0d, miscompares %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            conclude();
        end
    end

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        tick(4);
        rstn_i = 1'b1;
        rd_chk(charger_status_pkg::STATE_FLAGS_ADDR, 8'h00);
        rd_chk(charger_status_pkg::FAULT_FLAGS_ADDR, 8'h00);
        rd_chk(8'h7E, 8'h00);
        for (int i = 0; i < 24; i++) begin
            state_cond = (i == 0) ? 6'h3F : 6'($random(seed));
            tick(4);
            rd_chk(charger_status_pkg::STATE_FLAGS_ADDR, exp_state(state_cond));
        end
        wr(charger_status_pkg::STATE_FLAGS_ADDR, 8'h00);
        rd_chk(charger_status_pkg::STATE_FLAGS_ADDR, exp_state(state_cond));
        state_cond = '0;
        pulse_chk(10'h200, 8'h80);
        pulse_chk(10'h100, 8'h40);
        pulse_chk(10'h080, 8'h00);
        pulse_chk(10'h040, 8'h20);
        pulse_chk(10'h004, 8'h02);
        pulse_chk(10'h002, 8'h01);
        pass_thru = 1'b1;
        prot_en = 1'b1;
        pulse_chk(10'h080, 8'h40);
        prot_en = 1'b0;
        pulse_chk(10'h100, 8'h00);
        pass_thru = 1'b0;
        force_off = 1'b1;
        tick(5);
        // Level dropped first, else it sets the flag again and hides the clear
        force_off = 1'b0;
        pulse_chk(10'h000, 8'h04);
        wr(charger_status_pkg::FAULT_FLAGS_ADDR, 8'hFF);
        rd_chk(charger_status_pkg::FAULT_FLAGS_ADDR, 8'h00);
        fault_v = 10'h021;
        tick(5);
        chk("conv_en", 8'h00, {7'h00, conv_en});
        rd_chk(charger_status_pkg::FAULT_FLAGS_ADDR, 8'h10);
        wr(charger_status_pkg::FAULT_FLAGS_ADDR, 8'h00);
        rd_chk(charger_status_pkg::FAULT_FLAGS_ADDR, 8'h10);
        fault_v = 10'h001;
        tick(5);
        chk("conv_en", 8'h00, {7'h00, conv_en});
        wr(charger_status_pkg::FAULT_FLAGS_ADDR, 8'hFF);
        rd_chk(charger_status_pkg::FAULT_FLAGS_ADDR, 8'h10);
        wr(charger_status_pkg::FAULT_FLAGS_ADDR, 8'h00);
        chk("conv_en", 8'h01, {7'h00, conv_en});
        rd_chk(charger_status_pkg::FAULT_FLAGS_ADDR, 8'h00);
        fault_v = 10'h021;
        tick(5);
        fault_v = 10'h001;
        tick(5);
        fault_v = 10'h000;
        tick(5);
        chk("conv_en", 8'h01, {7'h00, conv_en});
        rd_chk(charger_status_pkg::FAULT_FLAGS_ADDR, 8'h00);
        fault_v = 10'h011;
        for (int i = 1; i <= NUV; i++) begin
            fault_v[3] = 1'b1;
            tick(1);
            fault_v[3] = 1'b0;
            tick(5);
            rd_chk(charger_status_pkg::FAULT_FLAGS_ADDR, (i == NUV) ? 8'h08 : 8'h00);
        end
        rd_chk(charger_status_pkg::FAULT_FLAGS_ADDR, 8'h08);
        fault_v = 10'h001;
        tick(5);
        wr(charger_status_pkg::FAULT_FLAGS_ADDR, 8'h00);
        rd_chk(charger_status_pkg::FAULT_FLAGS_ADDR, 8'h00);
        // Frozen core must not latch a fault that comes and goes
        clk_en = 1'b0;
        fault_v = 10'h201;
        tick(5);
        fault_v = 10'h001;
        tick(5);
        clk_en = 1'b1;
        tick(4);
        rd_chk(charger_status_pkg::FAULT_FLAGS_ADDR, 8'h00);
        conclude();
    end
endmodule // tb_top
